// File: swc_pkg.sv
/*
  Package for the sleep and wake-up controller: register offsets,
  field positions, reset values, timing counts and shared types.
  Assumes a 32-bit AHB-Lite register bus clocked by hclk at 50 MHz.
*/
`default_nettype none
package swc_pkg;
  // Byte offsets of the registers on the bus
  localparam logic [7:0] OFS_TIMER_OPTION_CONFIG = 8'h00;
  localparam logic [7:0] OFS_PROCESSOR_STATUS    = 8'h04;
  localparam logic [7:0] OFS_WATCHDOG_CONTROL    = 8'h08;
  localparam logic [7:0] OFS_WAKE_ENABLE         = 8'h0c;
  localparam logic [7:0] OFS_WAKE_CONTROL        = 8'h10;

  // Reset values
  localparam logic [7:0] RST_TIMER_OPTION_CONFIG = 8'hff;
  localparam logic [7:0] RST_WATCHDOG_CONTROL    = 8'h08;
  localparam logic [7:0] RST_WAKE_ENABLE         = 8'h00;
  localparam logic [7:0] RST_WAKE_CONTROL        = 8'h00;

  // Field positions
  localparam int POS_EXPIRY       = 4;
  localparam int POS_POWERDOWN    = 3;
  localparam int POS_SW_WDT_EN    = 0;
  localparam int POS_PERIOD_LO    = 1;
  localparam int POS_GLOBAL_IE    = 0;
  localparam int POS_PERIPH_IE    = 1;
  localparam int POS_CRYSTAL_MODE = 2;

  // Wake sources, one bit each in the wake enable register
  localparam int NUM_SOURCES = 8;
  localparam int SRC_TIMER1  = 0;
  localparam int SRC_CAPTURE = 1;
  localparam int SRC_CONVERT = 2;
  localparam int SRC_EEPROM  = 3;
  localparam int SRC_COMPARE = 4;
  localparam int SRC_PINCHG  = 5;
  localparam int SRC_EXTINT  = 6;
  localparam int SRC_TIMER0  = 7;
  // Sources gated by the peripheral interrupt enable
  localparam logic [7:0] PERIPH_MASK = 8'h1f;
  // Sources still able to fire with clocks stopped
  localparam logic [7:0] ASYNC_MASK  = 8'h7f;

  // Interrupt vector address
  localparam logic [12:0] IRQ_VECTOR = 13'h0004;

  // Oscillator start-up: 1024 oscillator periods, one per core clock
  localparam int OST_PERIODS = 1024;
  localparam int OST_CYCLES  = OST_PERIODS;

  // Watchdog period select base: 1:32 at code 0
  localparam int WDT_BASE_LOG2 = 5;

  typedef enum logic [3:0] {
    SWC_RUN   = 4'b0001,
    SWC_SLEEP = 4'b0010,
    SWC_START = 4'b0100,
    SWC_WAKE  = 4'b1000
  } swc_state_type;

  // Core-facing wake result
  typedef struct packed {
    logic        resume;
    logic        vector;
    logic [12:0] vector_addr;
  } swc_wake_type;
endpackage
`default_nettype wire

// File: swc_sleep_wakeup.sv
/*
  Sleep and wake-up controller: watchdog, status flags, oscillator gate,
  wake detection and result toward the core, AHB-Lite register slave.
  Assumes core signals are on hclk; reset pin and wake sources are async.
*/
`default_nettype none
// Behaviour
// - Force-on bit overrides software watchdog enable
// - Sleep clears watchdog, keeps it running
// - Sleep clears powerdown, sets expiry flag
// - Oscillator off while asleep
// - Port drive frozen during sleep
// - Watchdog reset internal, pin untouched
// - Reset pin low wakes by full reset
// - Watchdog or interrupt wake resumes execution
// - Powerdown and expiry both set at power-up
// - Listed peripheral sources can wake
// - Clocked peripherals silent while asleep
// - Next instruction prefetched during sleep
// - Enabled sources wake regardless of global
// - Global clear continues inline
// - Global set branches to vector
// - Watchdog cleared on every wake
// - Pending interrupt makes sleep a no-op
// - Late interrupt completes sleep, wakes
// - Crystal wake waits start-up delay
module swc_sleep_wakeup #(
  parameter int WDT_BITS    = 24,
  parameter int OST_CYCLES  = swc_pkg::OST_CYCLES,
  parameter int NUM_SOURCES = swc_pkg::NUM_SOURCES
) (
  input  wire logic                   hclk,
  input  wire logic                   hresetn,
  input  wire logic                   hsel,
  input  wire logic [31:0]            haddr,
  input  wire logic [1:0]             htrans,
  input  wire logic                   hwrite,
  input  wire logic [2:0]             hsize,
  input  wire logic [31:0]            hwdata,
  input  wire logic                   hready,
  output logic      [31:0]            hrdata,
  output logic                        hreadyout,
  output logic                        hresp,
  input  wire logic                   config_watchdog_force_on,
  input  wire logic                   sleep_exec,
  input  wire logic                   watchdog_clear_instruction,
  input  wire logic                   external_reset_pin_n,
  input  wire logic [NUM_SOURCES-1:0] irq_flags,
  output logic                        osc_enable,
  output logic                        hold_io,
  output logic                        core_stall,
  output logic                        prefetch_next,
  output logic                        internal_reset,
  output logic                        wake_pulse,
  output swc_pkg::swc_wake_type       wake_info
);
  swc_pkg::swc_state_type state;
  logic [7:0]          timer_option_config;
  logic [7:0]          watchdog_control;
  logic [7:0]          wake_enable;
  logic [7:0]          wake_control;
  logic                powerdown_flag;
  logic                watchdog_expiry_flag;
  logic [WDT_BITS-1:0] wdt_count;
  logic [10:0]         ost_count;
  logic                rst_meta;
  logic                rst_sync;
  logic [NUM_SOURCES-1:0] irq_meta;
  logic [NUM_SOURCES-1:0] irq_sync;
  logic                wdt_on;
  logic                wdt_expire;
  logic                irq_wake;
  logic [NUM_SOURCES-1:0] enabled_irq;
  logic                global_ie;
  logic                periph_ie;
  logic                crystal;
  logic                ap_write;
  logic                ap_read;
  logic                dp_write;
  logic [7:0]          dp_addr;
  logic [4:0]          wdt_shift;

  // Register offset match, used by read and write paths
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  assign global_ie = wake_control[swc_pkg::POS_GLOBAL_IE];
  assign periph_ie = wake_control[swc_pkg::POS_PERIPH_IE];
  assign crystal   = wake_control[swc_pkg::POS_CRYSTAL_MODE];

  // Synchronise reset pin and wake flags
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rst_meta <= 1'b1;
      rst_sync <= 1'b1;
      irq_meta <= '0;
      irq_sync <= '0;
    end else begin
      rst_meta <= external_reset_pin_n;
      rst_sync <= rst_meta;
      irq_meta <= irq_flags;
      irq_sync <= irq_meta;
    end
  end

  genvar g;
  generate
    for (g = 0; g < NUM_SOURCES; g++) begin : gen_src
      assign enabled_irq[g] = irq_sync[g] & wake_enable[g]
                            & (!swc_pkg::PERIPH_MASK[g] | periph_ie)
                            & (!(state == swc_pkg::SWC_SLEEP) | swc_pkg::ASYNC_MASK[g]);
    end
  endgenerate
  assign irq_wake = |enabled_irq;

  assign wdt_on    = config_watchdog_force_on | watchdog_control[swc_pkg::POS_SW_WDT_EN];
  assign wdt_shift = 5'(swc_pkg::WDT_BASE_LOG2) + {1'b0, watchdog_control[4:1]};
  assign wdt_expire = wdt_on && (state != swc_pkg::SWC_START)
                   && (32'(wdt_count) >= ((32'd1 << wdt_shift) - 32'd1));

  // Sleep and wake sequencing
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state     <= swc_pkg::SWC_RUN;
      ost_count <= '0;
    end else begin
      unique case (state)
        swc_pkg::SWC_RUN: begin
          // pending interrupt, sleep is a no-op
          if (sleep_exec && !irq_wake)
            state <= swc_pkg::SWC_SLEEP;
        end
        swc_pkg::SWC_SLEEP: begin
          if (!rst_sync || irq_wake || wdt_expire) begin
            state     <= crystal ? swc_pkg::SWC_START : swc_pkg::SWC_WAKE;
            ost_count <= '0;
          end
        end
        swc_pkg::SWC_START: begin
          ost_count <= ost_count + 11'd1;
          if (32'(ost_count) == OST_CYCLES - 1)
            state <= swc_pkg::SWC_WAKE;
        end
        swc_pkg::SWC_WAKE: state <= swc_pkg::SWC_RUN;
        default: state <= swc_pkg::SWC_RUN;
      endcase
    end
  end

  // Watchdog counter
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wdt_count <= '0;
    end else if (!wdt_on || watchdog_clear_instruction || wdt_expire) begin
      wdt_count <= '0;
    end else if (state == swc_pkg::SWC_RUN && sleep_exec && !irq_wake) begin
      wdt_count <= '0;
    end else if (state == swc_pkg::SWC_START || state == swc_pkg::SWC_WAKE) begin
      wdt_count <= '0;
    end else begin
      wdt_count <= wdt_count + 1'b1;
    end
  end

  // Status flags, active low
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      powerdown_flag       <= 1'b1;
      watchdog_expiry_flag <= 1'b1;
    end else if (watchdog_clear_instruction) begin
      powerdown_flag       <= 1'b1;
      watchdog_expiry_flag <= 1'b1;
    end else if (state == swc_pkg::SWC_RUN && sleep_exec && !irq_wake) begin
      powerdown_flag       <= 1'b0;
      watchdog_expiry_flag <= 1'b1;
    end else if (wdt_expire) begin
      watchdog_expiry_flag <= 1'b0;
    end
  end

  // Outputs to core and pads
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      osc_enable     <= 1'b1;
      hold_io        <= 1'b0;
      prefetch_next  <= 1'b0;
      internal_reset <= 1'b0;
      wake_pulse     <= 1'b0;
      wake_info      <= '0;
    end else begin
      osc_enable    <= !(state == swc_pkg::SWC_SLEEP);
      hold_io       <= (state == swc_pkg::SWC_SLEEP) || (state == swc_pkg::SWC_START);
      prefetch_next <= (state == swc_pkg::SWC_RUN) && sleep_exec;
      // reset pin low during sleep resets
      internal_reset <= (wdt_expire && state == swc_pkg::SWC_RUN)
                     || (!rst_sync && state == swc_pkg::SWC_SLEEP);
      wake_pulse <= (state == swc_pkg::SWC_WAKE);
      if (state == swc_pkg::SWC_SLEEP && rst_sync && (irq_wake || wdt_expire)) begin
        wake_info.resume      <= 1'b1;
        wake_info.vector      <= irq_wake && global_ie;
        wake_info.vector_addr <= swc_pkg::IRQ_VECTOR;
      end else if (state == swc_pkg::SWC_SLEEP && !rst_sync) begin
        wake_info <= '0;
      end
    end
  end
  assign core_stall = (state != swc_pkg::SWC_RUN);

  // AHB-Lite data phase capture
  assign ap_write = hsel && hready && htrans[1] && hwrite;
  assign ap_read  = hsel && hready && htrans[1] && !hwrite;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_write <= 1'b0;
      dp_addr  <= '0;
    end else if (hready) begin
      dp_write <= ap_write;
      dp_addr  <= haddr[7:0];
    end
  end

  // Register writes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      timer_option_config <= swc_pkg::RST_TIMER_OPTION_CONFIG;
      watchdog_control    <= swc_pkg::RST_WATCHDOG_CONTROL;
      wake_enable         <= swc_pkg::RST_WAKE_ENABLE;
      wake_control        <= swc_pkg::RST_WAKE_CONTROL;
    end else if (dp_write) begin
      if (hit(dp_addr, swc_pkg::OFS_TIMER_OPTION_CONFIG))
        timer_option_config <= hwdata[7:0];
      if (hit(dp_addr, swc_pkg::OFS_WATCHDOG_CONTROL))
        watchdog_control <= {3'b000, hwdata[4:0]};
      if (hit(dp_addr, swc_pkg::OFS_WAKE_ENABLE))
        wake_enable <= hwdata[7:0];
      if (hit(dp_addr, swc_pkg::OFS_WAKE_CONTROL))
        wake_control <= {5'b00000, hwdata[2:0]};
    end
  end

  // Read data registered at address phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= '0;
    end else if (ap_read) begin
      hrdata <= '0;
      if (hit(haddr[7:0], swc_pkg::OFS_TIMER_OPTION_CONFIG))
        hrdata[7:0] <= timer_option_config;
      if (hit(haddr[7:0], swc_pkg::OFS_PROCESSOR_STATUS))
        hrdata[7:0] <= {3'b000, watchdog_expiry_flag, powerdown_flag, 3'b000};
      if (hit(haddr[7:0], swc_pkg::OFS_WATCHDOG_CONTROL))
        hrdata[7:0] <= watchdog_control;
      if (hit(haddr[7:0], swc_pkg::OFS_WAKE_ENABLE))
        hrdata[7:0] <= wake_enable;
      if (hit(haddr[7:0], swc_pkg::OFS_WAKE_CONTROL))
        hrdata[7:0] <= wake_control;
    end
  end
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // Assertions
  AST_SLEEP_FLAGS: assert property (@(posedge hclk) disable iff (!hresetn)
    (state == swc_pkg::SWC_RUN && sleep_exec && !irq_wake && !watchdog_clear_instruction)
    |=> (!powerdown_flag && watchdog_expiry_flag))
    else $error("sleep entry did not update flags");
  AST_NOP_SLEEP: assert property (@(posedge hclk) disable iff (!hresetn)
    (state == swc_pkg::SWC_RUN && sleep_exec && irq_wake && !watchdog_clear_instruction)
    |=> ($stable(powerdown_flag) && state == swc_pkg::SWC_RUN))
    else $error("pending interrupt sleep was not a no-op");
  AST_OSC_OFF: assert property (@(posedge hclk) disable iff (!hresetn)
    (state == swc_pkg::SWC_SLEEP) |=> !osc_enable || state != swc_pkg::SWC_SLEEP)
    else $error("oscillator running in sleep");
  AST_WDT_CLEAR: assert property (@(posedge hclk) disable iff (!hresetn)
    (state == swc_pkg::SWC_RUN && sleep_exec && !irq_wake) |=> (wdt_count == '0))
    else $error("watchdog not cleared at sleep");
  AST_WAKE_CLEAR: assert property (@(posedge hclk) disable iff (!hresetn)
    (state == swc_pkg::SWC_WAKE) |=> (wdt_count == '0))
    else $error("watchdog not cleared at wake");
  AST_FORCE_ON: assert property (@(posedge hclk) disable iff (!hresetn)
    config_watchdog_force_on |-> wdt_on)
    else $error("force-on did not enable watchdog");
  AST_IRQ_WAKE: assert property (@(posedge hclk) disable iff (!hresetn)
    (state == swc_pkg::SWC_SLEEP && irq_wake && rst_sync && !crystal)
    |=> state == swc_pkg::SWC_WAKE ##1 wake_pulse && wake_info.resume)
    else $error("interrupt wake did not resume");
  AST_PIN_RESET: assert property (@(posedge hclk) disable iff (!hresetn)
    (state == swc_pkg::SWC_SLEEP && !rst_sync) |=> internal_reset)
    else $error("reset pin wake did not reset");
  AST_VECTOR: assert property (@(posedge hclk) disable iff (!hresetn)
    (state == swc_pkg::SWC_SLEEP && irq_wake && rst_sync && !global_ie)
    |=> !wake_info.vector)
    else $error("vector taken with global enable clear");

  // Further guards on sleep, wake and watchdog behaviour
  AST_HOLD_IO: assert property (@(posedge hclk) disable iff (!hresetn)
    (state == swc_pkg::SWC_SLEEP) |=> hold_io)
    else $error("port drive not held in sleep");
  AST_WDT_RESET: assert property (@(posedge hclk) disable iff (!hresetn)
    (wdt_expire && state == swc_pkg::SWC_RUN) |=> internal_reset)
    else $error("watchdog expiry gave no internal reset");
  AST_WDT_RESUME: assert property (@(posedge hclk) disable iff (!hresetn)
    (state == swc_pkg::SWC_SLEEP && rst_sync && wdt_expire)
    |=> (wake_info.resume && !internal_reset))
    else $error("watchdog wake did not resume");
  AST_EXPIRY_WAKE: assert property (@(posedge hclk) disable iff (!hresetn)
    (state == swc_pkg::SWC_SLEEP && wdt_expire && !watchdog_clear_instruction)
    |=> !watchdog_expiry_flag)
    else $error("watchdog wake left expiry flag set");
  AST_PREFETCH: assert property (@(posedge hclk) disable iff (!hresetn)
    (state == swc_pkg::SWC_RUN && sleep_exec) |=> prefetch_next)
    else $error("no prefetch during sleep instruction");
  AST_ANY_GLOBAL: assert property (@(posedge hclk) disable iff (!hresetn)
    (state == swc_pkg::SWC_SLEEP && irq_wake) |=> (state != swc_pkg::SWC_SLEEP))
    else $error("enabled interrupt did not leave sleep");
  AST_INLINE_RESUME: assert property (@(posedge hclk) disable iff (!hresetn)
    (state == swc_pkg::SWC_SLEEP && irq_wake && rst_sync && !global_ie)
    |=> wake_info.resume)
    else $error("inline wake did not resume");
  AST_VECTOR_SET: assert property (@(posedge hclk) disable iff (!hresetn)
    (state == swc_pkg::SWC_SLEEP && irq_wake && rst_sync && global_ie)
    |=> (wake_info.vector && wake_info.vector_addr == swc_pkg::IRQ_VECTOR))
    else $error("vector not taken with global enable set");
  AST_START_CLEAR: assert property (@(posedge hclk) disable iff (!hresetn)
    (state == swc_pkg::SWC_START) |=> (wdt_count == '0))
    else $error("watchdog counted during start-up");
  AST_CRYSTAL_START: assert property (@(posedge hclk) disable iff (!hresetn)
    (state == swc_pkg::SWC_SLEEP && crystal && (irq_wake || wdt_expire || !rst_sync))
    |=> (state == swc_pkg::SWC_START))
    else $error("crystal wake skipped start-up delay");
  AST_START_HOLD: assert property (@(posedge hclk) disable iff (!hresetn)
    (state == swc_pkg::SWC_START && 32'(ost_count) < OST_CYCLES - 1)
    |=> (state == swc_pkg::SWC_START))
    else $error("start-up delay ended early");
  AST_CLOCKED_QUIET: assert property (@(posedge hclk) disable iff (!hresetn)
    (state == swc_pkg::SWC_SLEEP) |-> ((enabled_irq & ~swc_pkg::ASYNC_MASK) == '0))
    else $error("clocked source active in sleep");
  AST_OSC_RESTART: assert property (@(posedge hclk) disable iff (!hresetn)
    (state == swc_pkg::SWC_START || state == swc_pkg::SWC_WAKE) |=> osc_enable)
    else $error("oscillator not restarted on wake");
  AST_SW_OFF: assert property (@(posedge hclk) disable iff (!hresetn)
    (!config_watchdog_force_on && !watchdog_control[swc_pkg::POS_SW_WDT_EN])
    |=> (wdt_count == '0))
    else $error("watchdog counted while disabled");
  AST_PIN_NO_RESUME: assert property (@(posedge hclk) disable iff (!hresetn)
    (state == swc_pkg::SWC_SLEEP && !rst_sync) |=> !wake_info.resume)
    else $error("reset pin wake marked as resume");
endmodule
`default_nettype wire

// File: swc_core_model.sv
/*
  Core-side partner: issues the sleep instruction, optionally preceded by
  a watchdog clear, and remembers the prefetch pulse. Assumes hclk domain.
*/
`default_nettype none
module swc_core_model (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic go_sleep,
  input  wire logic with_clear,
  input  wire logic prefetch_next,
  output logic      sleep_exec,
  output logic      watchdog_clear_instruction,
  output logic      prefetch_seen
);
  timeunit 1ns;
  timeprecision 1ps;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      watchdog_clear_instruction <= 1'b0;
      sleep_exec                 <= 1'b0;
    end else begin
      watchdog_clear_instruction <= go_sleep & with_clear;
      sleep_exec                 <= (go_sleep & ~with_clear) | watchdog_clear_instruction;
    end
  end
  // Sticky prefetch marker, cleared per request
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prefetch_seen <= 1'b0;
    end else if (go_sleep) begin
      prefetch_seen <= 1'b0;
    end else if (prefetch_next) begin
      prefetch_seen <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// File: tb.sv
/*
  Testbench for the sleep and wake-up controller: bus tasks, one task per
  scenario, watchdog. Assumes one hclk domain and the core partner model.
*/
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int OST = 8;
  logic                  hclk, hresetn, hsel, hwrite, force_on, clr_req, go, ext_n;
  logic                  hreadyout, hresp, osc_enable, hold_io, core_stall, prefetch_next;
  logic                  internal_reset, wake_pulse, sleep_exec, wclr, pf_seen;
  logic [31:0]           haddr, hwdata, hrdata, rd;
  logic [1:0]            htrans;
  logic [7:0]            irq;
  swc_pkg::swc_wake_type wake_info;
  int                    n_errors, samples_checked, n_base, n;

  swc_sleep_wakeup #(.OST_CYCLES(OST)) swc_sleep_wakeup_inst (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .config_watchdog_force_on(force_on), .sleep_exec(sleep_exec),
    .watchdog_clear_instruction(wclr), .external_reset_pin_n(ext_n), .irq_flags(irq),
    .osc_enable(osc_enable), .hold_io(hold_io), .core_stall(core_stall),
    .prefetch_next(prefetch_next), .internal_reset(internal_reset),
    .wake_pulse(wake_pulse), .wake_info(wake_info));
  swc_core_model swc_core_model_inst (
    .hclk(hclk), .hresetn(hresetn), .go_sleep(go), .with_clear(clr_req),
    .prefetch_next(prefetch_next), .sleep_exec(sleep_exec),
    .watchdog_clear_instruction(wclr), .prefetch_seen(pf_seen));

  // Clock, 20 ns period
  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One AHB-Lite single transfer, waits on hready in both phases
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, {24'h0, d});
  endtask

  task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] m,
                       input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(what, exp, rd & m);
  endtask

  task automatic do_sleep(input logic c);
    @(posedge hclk);
    go <= 1'b1;
    clr_req <= c;
    @(posedge hclk);
    go <= 1'b0;
    repeat (5) @(posedge hclk);
    #1;
  endtask

  // Counts cycles until wake pulse (0) or internal reset (1), 80 at most
  task automatic wait_hi(input int sel, output int k);
    k = 0;
    while ((sel ? internal_reset : wake_pulse) !== 1'b1 && k < 80) begin
      @(posedge hclk);
      #1;
      k++;
    end
  endtask

  task automatic t_regs();
    rdchk("option", swc_pkg::OFS_TIMER_OPTION_CONFIG, 32'hffffffff, 32'hff);
    rdchk("wdt ctl", swc_pkg::OFS_WATCHDOG_CONTROL, 32'hffffffff, 32'h08);
    rdchk("wake en", swc_pkg::OFS_WAKE_ENABLE, 32'hffffffff, 32'h00);
    rdchk("flags", swc_pkg::OFS_PROCESSOR_STATUS, 32'h18, 32'h18);
    wr(8'h20, 8'h5a);
    rdchk("unmapped", 8'h20, 32'hffffffff, 32'h0);
    wr(swc_pkg::OFS_TIMER_OPTION_CONFIG, 8'h3c);
    rdchk("option rw", swc_pkg::OFS_TIMER_OPTION_CONFIG, 32'hffffffff, 32'h3c);
    chk("hresp", 32'h0, hresp);
  endtask

  task automatic t_pin(input logic g);
    wr(swc_pkg::OFS_WAKE_ENABLE, 8'h20);
    wr(swc_pkg::OFS_WAKE_CONTROL, {7'h0, g});
    do_sleep(1'b0);
    chk("osc off", 32'h0, osc_enable);
    chk("io hold", 32'h1, hold_io);
    chk("prefetch", 32'h1, pf_seen);
    chk("stall", 32'h1, core_stall);
    rdchk("flags", swc_pkg::OFS_PROCESSOR_STATUS, 32'h18, 32'h10);
    irq <= 8'h20;
    wait_hi(0, n);
    chk("pin wake", 32'h1, n < 80);
    chk("resume", 32'h1, wake_info.resume);
    chk("vector", {31'h0, g}, wake_info.vector);
    if (g) chk("vector addr", 32'h4, wake_info.vector_addr);
    irq <= 8'h00;
    repeat (3) @(posedge hclk);
    #1;
    chk("osc on", 32'h1, osc_enable);
    chk("stall off", 32'h0, core_stall);
    if (!g) n_base = n;
  endtask

  task automatic t_periph();
    wr(swc_pkg::OFS_WAKE_ENABLE, 8'h81);
    wr(swc_pkg::OFS_WAKE_CONTROL, 8'h02);
    do_sleep(1'b0);
    irq <= 8'h80;
    repeat (20) @(posedge hclk);
    #1;
    chk("clocked source", 32'h0, osc_enable);
    wr(swc_pkg::OFS_WAKE_CONTROL, 8'h00);
    irq <= 8'h81;
    repeat (20) @(posedge hclk);
    #1;
    chk("periph gate", 32'h0, osc_enable);
    wr(swc_pkg::OFS_WAKE_CONTROL, 8'h02);
    repeat (15) @(posedge hclk);
    #1;
    chk("periph wake", 32'h1, osc_enable);
    irq <= 8'h00;
  endtask

  task automatic t_pending();
    wr(swc_pkg::OFS_WAKE_ENABLE, 8'h20);
    wr(swc_pkg::OFS_WAKE_CONTROL, 8'h00);
    irq <= 8'h20;
    repeat (4) @(posedge hclk);
    do_sleep(1'b1);
    chk("no-op osc", 32'h1, osc_enable);
    rdchk("no-op flags", swc_pkg::OFS_PROCESSOR_STATUS, 32'h18, 32'h18);
    irq <= 8'h00;
  endtask

  task automatic t_crystal();
    wr(swc_pkg::OFS_WAKE_CONTROL, 8'h04);
    do_sleep(1'b0);
    irq <= 8'h20;
    wait_hi(0, n);
    chk("start-up delay", 32'h1, n >= n_base + OST && n < 80);
    irq <= 8'h00;
    wr(swc_pkg::OFS_WAKE_CONTROL, 8'h00);
  endtask

  task automatic t_wdt();
    wr(swc_pkg::OFS_WATCHDOG_CONTROL, 8'h01);
    wait_hi(1, n);
    chk("sw wdt expiry", 32'h1, n < 80);
    wr(swc_pkg::OFS_WATCHDOG_CONTROL, 8'h01);
    do_sleep(1'b0);
    wait_hi(0, n);
    chk("wdt wake time", 32'h1, n >= 20 && n < 80);
    chk("wdt resume", 32'h1, wake_info.resume);
    wait_hi(1, n);
    chk("wdt cleared on wake", 32'h1, n >= 20 && n < 80);
    rdchk("expiry flag", swc_pkg::OFS_PROCESSOR_STATUS, 32'h10, 32'h00);
    wr(swc_pkg::OFS_WATCHDOG_CONTROL, 8'h00);
    force_on <= 1'b1;
    wait_hi(1, n);
    chk("forced wdt", 32'h1, n < 80);
    // Let the last reset pulse drop before watching for a new one
    @(posedge hclk);
    force_on <= 1'b0;
    #1;
    wait_hi(1, n);
    chk("wdt off", 32'd80, n);
  endtask

  task automatic t_rstpin();
    do_sleep(1'b0);
    ext_n <= 1'b0;
    wait_hi(1, n);
    chk("pin reset", 32'h1, n < 80);
    ext_n <= 1'b1;
  endtask

  task automatic end_sim();
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Hang guard
  initial begin
    #200us;
    n_errors++;
    $display("CHECK FAILED run time expected done seen timeout");
    end_sim();
  end

  // Main sequence
  initial begin
    {hresetn, hsel, hwrite, force_on, clr_req, go} = 6'h00;
    {haddr, hwdata, htrans, irq} = '0;
    ext_n = 1'b1;
    n_base = 0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs();
    t_pin(1'b0);
    t_pin(1'b1);
    t_periph();
    t_pending();
    t_crystal();
    t_wdt();
    t_rstpin();
    end_sim();
  end
endmodule
`default_nettype wire
